//--- verilog/aims_top.sv
/*
  Input and reference selection of a 10-bit successive-approximation
  converter: one selection register, deferred application, decode.
  Assumes a converter core reporting busy and a one-cycle done pulse.
*/
// Our own choice: strobed register access.
//
// Overview of operation
// R1: Temperature code routes and enables the sensor.
// R2: Software picks internal reference for temperature.
// R3: Software uses single conversion for temperature.
// R4: Reference change waits for conversion done.
// R5: Channel change waits for conversion done.
// R6: Software waits settling after new differential pair.
// R7: Same settling after a reference change.
// R8: Decode reference bits: supply, external, internal.
// R9: Code 11 ties internal reference to pin.
// R10: Lowest code bit picks 1x or 20x.
// R11: Highest code bit swaps differential polarity.
// R12: Calibration codes tie one pin to both.
// R13: Decode differential pairs from the code.
// R14: Done flag marks result update; deferred apply.
// R15: Codes 0 to 7 pick single inputs.
`timescale 1ns/1ps
`default_nettype none
module aims_top (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic       conv_busy_in,
  input  wire logic       conv_done_in,
  output logic      [7:0] rdata_out,
  output logic      [3:0] pos_input_out,
  output logic      [3:0] neg_input_out,
  output logic            gain_high_out,
  output logic            temp_enable_out,
  output logic            differential_out,
  output logic            ref_supply_out,
  output logic            ref_external_out,
  output logic            ref_internal_out,
  output logic            ref_to_pin_out,
  output logic            pending_out
);
  logic [7:0] input_reference_select_q;
  logic [7:0] applied_q;
  logic       pending_q;
  logic [1:0] ref_bits;
  logic       hit;
  aims_sel_if sel ();

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  assign hit = (addr_in == aims_pkg::AIMS_REG_ADDR);

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      input_reference_select_q <= aims_pkg::AIMS_REG_RESET;
    else if (wr_in && hit)
      input_reference_select_q <= wdata_in;
  end

  // Unmapped addresses read as zero.
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= 8'h00;
    else if (rd_in && hit)
      rdata_out <= input_reference_select_q;
    else
      rdata_out <= 8'h00;
  end

  // ---------------------------------------------------------------
  // Deferred application
  // ---------------------------------------------------------------
  // A done pulse applies the latest value; a write in that same cycle is
  // applied at once, since the conversion it would disturb has ended.
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      applied_q <= aims_pkg::AIMS_REG_RESET;
    else if (wr_in && hit && (!conv_busy_in || conv_done_in))
      applied_q <= wdata_in; // R4 R5
    else if (conv_done_in && pending_q)
      applied_q <= input_reference_select_q; // R14
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pending_q <= 1'b0;
    else if (wr_in && hit && conv_busy_in && !conv_done_in)
      pending_q <= 1'b1; // R4 R5
    else if (conv_done_in || !conv_busy_in)
      pending_q <= 1'b0; // R14
  end

  assign sel.applied = applied_q;

  aims_decode u_decode (
    .sel (sel)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign ref_bits = applied_q[aims_pkg::AIMS_REF_HI:aims_pkg::AIMS_REF_LO];

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ref_supply_out   <= 1'b1;
      ref_external_out <= 1'b0;
      ref_internal_out <= 1'b0;
      ref_to_pin_out   <= 1'b0;
    end
    else
    begin
      ref_supply_out   <= (ref_bits == aims_pkg::AIMS_REF_SUPPLY); // R8
      ref_external_out <= (ref_bits == aims_pkg::AIMS_REF_EXTERNAL); // R8
      ref_internal_out <= (ref_bits == aims_pkg::AIMS_REF_INTERNAL) ||
                          (ref_bits == aims_pkg::AIMS_REF_TIED); // R8 R9
      ref_to_pin_out   <= (ref_bits == aims_pkg::AIMS_REF_TIED); // R9
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pos_input_out    <= 4'h0;
      neg_input_out    <= aims_pkg::AIMS_IN_NONE;
      gain_high_out    <= 1'b0;
      temp_enable_out  <= 1'b0;
      differential_out <= 1'b0;
      pending_out      <= 1'b0;
    end
    else
    begin
      pos_input_out    <= sel.pos_input; // R13
      neg_input_out    <= sel.neg_input; // R13
      gain_high_out    <= sel.gain_high &&
                          (sel.mode == aims_pkg::AIMS_MODE_DIFF); // R10
      temp_enable_out  <= sel.temp_enable; // R1
      differential_out <= (sel.mode == aims_pkg::AIMS_MODE_DIFF);
      pending_out      <= pending_q;
    end
  end
endmodule // aims_top
`default_nettype wire

//--- shared/aims_pkg.sv
/*
  Package of the converter input and reference selection block: register
  offset, field layout, decode codes and encodings.
  Assumes a single 40 MHz system clock and an 8-bit register port.
*/
package aims_pkg;
  localparam logic [7:0] AIMS_REG_ADDR      = 8'h07;
  localparam logic [7:0] AIMS_REG_RESET     = 8'h00;
  localparam int         AIMS_REF_HI        = 7;
  localparam int         AIMS_REF_LO        = 6;
  localparam int         AIMS_CODE_HI       = 5;
  localparam int         AIMS_CODE_LO       = 0;
  localparam int         AIMS_SWAP_BIT      = 5;
  localparam int         AIMS_GAIN_BIT      = 0;
  localparam logic [1:0] AIMS_REF_SUPPLY    = 2'h0;
  localparam logic [1:0] AIMS_REF_EXTERNAL  = 2'h1;
  localparam logic [1:0] AIMS_REF_INTERNAL  = 2'h2;
  localparam logic [1:0] AIMS_REF_TIED      = 2'h3;
  localparam logic [5:0] AIMS_CODE_TEMP     = 6'h22;
  localparam logic [5:0] AIMS_CODE_CAL0     = 6'h23;
  localparam logic [5:0] AIMS_CODE_CAL3_1X  = 6'h24;
  localparam logic [5:0] AIMS_CODE_CAL3_20X = 6'h25;
  localparam logic [5:0] AIMS_CODE_CAL7_1X  = 6'h26;
  localparam logic [5:0] AIMS_CODE_CAL7_20X = 6'h27;
  localparam logic [5:0] AIMS_CODE_SE_MAX   = 6'h07;
  localparam logic [5:0] AIMS_CODE_DIFF_MIN = 6'h08;
  localparam logic [5:0] AIMS_CODE_DIFF_MAX = 6'h1F;
  localparam logic [5:0] AIMS_CODE_SWAP_MIN = 6'h28;
  localparam logic [3:0] AIMS_IN_TEMP       = 4'h8;
  localparam logic [3:0] AIMS_IN_NONE       = 4'hF;

  typedef enum logic [2:0] {
    AIMS_MODE_SINGLE = 3'h1,
    AIMS_MODE_DIFF   = 3'h2,
    AIMS_MODE_NONE   = 3'h4
  } aims_mode_t;
endpackage

//--- shared/aims_sel_if.sv
/*
  Interface carrying the applied selection code from the register module
  to the decoder. Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface aims_sel_if;
  logic [7:0] applied;
  logic [3:0] pos_input;
  logic [3:0] neg_input;
  logic       gain_high;
  logic       temp_enable;
  logic [2:0] mode;
  modport ctrl (output applied, input pos_input, neg_input, gain_high,
                temp_enable, mode);
  modport dec  (input applied, output pos_input, neg_input, gain_high,
                temp_enable, mode);
endinterface
`default_nettype wire

//--- verilog/aims_decode.sv
/*
  Combinational decoder from the applied channel and gain code to the
  positive input, negative input, gain and sensor enable.
  Assumes the applied code only changes between conversions.
*/
`timescale 1ns/1ps
`default_nettype none
module aims_decode (
  aims_sel_if.dec sel
);
  logic [5:0] code;
  logic [5:0] base;
  logic [3:0] p;
  logic [3:0] n;
  assign code = sel.applied[aims_pkg::AIMS_CODE_HI:aims_pkg::AIMS_CODE_LO];
  assign sel.gain_high = code[aims_pkg::AIMS_GAIN_BIT]; // R10

  always_comb
  begin
    base = {1'b0, code[4:1], 1'b0};
    p = aims_pkg::AIMS_IN_NONE;
    n = aims_pkg::AIMS_IN_NONE;
    sel.mode = aims_pkg::AIMS_MODE_NONE;
    sel.temp_enable = 1'b0;
    if (code <= aims_pkg::AIMS_CODE_SE_MAX)
    begin
      p = code[3:0]; // R15
      sel.mode = aims_pkg::AIMS_MODE_SINGLE;
    end
    else if (code == aims_pkg::AIMS_CODE_TEMP)
    begin
      p = aims_pkg::AIMS_IN_TEMP; // R1
      sel.temp_enable = 1'b1; // R1
      sel.mode = aims_pkg::AIMS_MODE_SINGLE;
    end
    else if (code == aims_pkg::AIMS_CODE_CAL0)
    begin
      p = 4'h0; // R12
      n = 4'h0;
      sel.mode = aims_pkg::AIMS_MODE_DIFF;
    end
    else if (code == aims_pkg::AIMS_CODE_CAL3_1X ||
             code == aims_pkg::AIMS_CODE_CAL3_20X)
    begin
      p = 4'h3; // R12
      n = 4'h3;
      sel.mode = aims_pkg::AIMS_MODE_DIFF;
    end
    else if (code == aims_pkg::AIMS_CODE_CAL7_1X ||
             code == aims_pkg::AIMS_CODE_CAL7_20X)
    begin
      p = 4'h7; // R12
      n = 4'h7;
      sel.mode = aims_pkg::AIMS_MODE_DIFF;
    end
    else if (code >= aims_pkg::AIMS_CODE_DIFF_MIN)
    begin
      sel.mode = aims_pkg::AIMS_MODE_DIFF; // R13
      case (base[4:0])
        5'h08: begin p = 4'h0; n = 4'h1; end
        5'h0A: begin p = 4'h0; n = 4'h3; end
        5'h0C: begin p = 4'h1; n = 4'h2; end
        5'h0E: begin p = 4'h1; n = 4'h3; end
        5'h10: begin p = 4'h2; n = 4'h3; end
        5'h12: begin p = 4'h3; n = 4'h4; end
        5'h14: begin p = 4'h3; n = 4'h5; end
        5'h16: begin p = 4'h3; n = 4'h6; end
        5'h18: begin p = 4'h3; n = 4'h7; end
        5'h1A: begin p = 4'h4; n = 4'h5; end
        5'h1C: begin p = 4'h5; n = 4'h6; end
        5'h1E: begin p = 4'h6; n = 4'h7; end
        default: sel.mode = aims_pkg::AIMS_MODE_NONE;
      endcase
      // Codes 20 and 21 hex fall to the default and stay unconnected.
      if (code[aims_pkg::AIMS_SWAP_BIT])
      begin
        // The upper half repeats the lower pairs with the inputs exchanged.
        {p, n} = {n, p}; // R11
      end
    end
  end

  assign sel.pos_input = p;
  assign sel.neg_input = n;
endmodule // aims_decode
`default_nettype wire

//--- sim/aims_conv_model.sv
/*
  Behavioural converter core: busy for a fixed span after a start pulse,
  with a one-cycle done pulse in its last busy cycle.
  Assumes start is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module aims_conv_model #(parameter int CYCLES = 13) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic start_in,
  output logic      busy_out,
  output logic      done_out
);
  int cnt_q;
  // Done overlaps the last busy cycle, as a real core raises its flag.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      cnt_q    <= 0;
    end
    else
    begin
      done_out <= busy_out && cnt_q == 1;
      busy_out <= busy_out ? cnt_q != 0 : start_in;
      cnt_q    <= busy_out ? cnt_q - 1 : CYCLES;
    end
  end
endmodule // aims_conv_model
`default_nettype wire

//--- sim/aims_top_checker.sv
/*
  Port checker of aims_top, bound to every instance.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module aims_top_checker (
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       conv_busy_in,
  input wire logic       conv_done_in,
  input wire logic [3:0] pos_input_out,
  input wire logic [3:0] neg_input_out,
  input wire logic       gain_high_out,
  input wire logic       temp_enable_out,
  input wire logic       differential_out,
  input wire logic       ref_supply_out,
  input wire logic       ref_external_out,
  input wire logic       ref_internal_out,
  input wire logic       ref_to_pin_out,
  input wire logic       pending_out
);
  logic       now_w;
  logic [5:0] code_w;
  // Idle writes and done-cycle writes land at once; only idle ones are checked, busy ones are left out.
  assign now_w  = wr_in && !conv_busy_in
                  && addr_in == aims_pkg::AIMS_REG_ADDR;
  assign code_w = wdata_in[5:0];
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  a_temp_route: assert property (now_w && code_w == 6'h22 |-> ##2
    pos_input_out == 4'h8 && temp_enable_out) else $error("temp not routed");
  a_ref_decode: assert property (now_w && !wdata_in[7] |-> ##2
    ref_supply_out != $past(wdata_in[6], 2) && !ref_internal_out
    && ref_external_out == $past(wdata_in[6], 2)) else $error("bad ref");
  a_ref_tied: assert property (now_w && wdata_in[7:6] == 2'h3 |-> ##2
    ref_internal_out && ref_to_pin_out) else $error("ref not tied to pin");
  a_gain_bit: assert property (now_w && code_w inside {[6'h08:6'h1F]}
    |-> ##2 differential_out && gain_high_out == $past(wdata_in[0], 2))
    else $error("bad gain");
  a_cal_same: assert property (now_w && code_w inside {[6'h23:6'h27]}
    |-> ##2 differential_out && pos_input_out == neg_input_out)
    else $error("calibration inputs differ");
  a_single_pin: assert property (now_w && code_w <= 6'h07 |-> ##2
    pos_input_out == $past(wdata_in[3:0], 2) && neg_input_out == 4'hF
    && !differential_out) else $error("bad single input");
  a_hold_busy: assert property (pending_out && !conv_done_in
    && !$past(conv_done_in) |=> $stable({pos_input_out, neg_input_out,
    gain_high_out, ref_internal_out, ref_external_out}))
    else $error("selection moved during conversion");
  a_done_apply: assert property (conv_done_in && pending_out
    |-> ##2 !pending_out) else $error("pending not cleared");
  a_ref_internal: assert property (now_w
    && wdata_in[7:6] == 2'h2 |-> ##2 ref_internal_out && !ref_to_pin_out
    && !ref_supply_out && !ref_external_out) else $error("bad internal ref");
  a_swap_pair: assert property (now_w
    && code_w >= aims_pkg::AIMS_CODE_SWAP_MIN |-> ##2 differential_out
    && pos_input_out != neg_input_out
    && gain_high_out == $past(wdata_in[0], 2)) else $error("bad swapped pair");
endmodule // aims_top_checker
bind aims_top aims_top_checker chk_u (.mclk_in(mclk_in),
  .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .conv_busy_in(conv_busy_in), .conv_done_in(conv_done_in),
  .pos_input_out(pos_input_out), .neg_input_out(neg_input_out),
  .gain_high_out(gain_high_out), .temp_enable_out(temp_enable_out),
  .differential_out(differential_out), .ref_supply_out(ref_supply_out),
  .ref_external_out(ref_external_out), .ref_internal_out(ref_internal_out),
  .ref_to_pin_out(ref_to_pin_out), .pending_out(pending_out));
`default_nettype wire

//--- sim/adc_input_mux_select_bench.sv
/*
  Bench of aims_top: register tasks, full code sweep, deferred change.
  Assumes aims_conv_model stands in for the converter core.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_input_mux_select_bench;
  localparam logic [47:0] POS_L = 48'h001123333456;
  localparam logic [47:0] NEG_L = 48'h132334567567;
  logic             mclk_in = 1'b0;
  logic             rst_n_in, wr_in, rd_in, start_q;
  logic       [7:0] addr_in, wdata_in, v, r;
  wire logic  [7:0] rdata_out;
  wire logic [15:0] sel_w;
  wire logic        busy_w, done_w;
  int               err_total = 0, checked = 0;
  always #12.5 mclk_in = ~mclk_in;
  aims_top dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .conv_busy_in(busy_w),
    .conv_done_in(done_w), .rdata_out(rdata_out), .pending_out(sel_w[15]),
    .ref_supply_out(sel_w[14]), .ref_external_out(sel_w[13]),
    .ref_internal_out(sel_w[12]), .ref_to_pin_out(sel_w[11]),
    .differential_out(sel_w[10]), .temp_enable_out(sel_w[9]),
    .gain_high_out(sel_w[8]), .pos_input_out(sel_w[7:4]),
    .neg_input_out(sel_w[3:0]));
  aims_conv_model conv_u (.clk_in(mclk_in), .rst_n_in(rst_n_in),
    .start_in(start_q), .busy_out(busy_w), .done_out(done_w));
  function automatic logic [15:0] exp_sel(input logic [7:0] e,
                                          input logic       pend);
    logic [5:0] c;
    logic [3:0] p, n, k;
    logic       d;
    c = e[5:0];
    k = c[4:1] - 4'h4;
    d = c > 6'h22 || c[4:3] != 2'h0;
    p = c <= 6'h07 ? c[3:0] : c == 6'h22 ? 4'h8 : 4'hF;
    n = 4'hF;
    if (c > 6'h22 && c < 6'h28)
    begin
      p = c < 6'h24 ? 4'h0 : c < 6'h26 ? 4'h3 : 4'h7;
      n = p;
    end
    else if (d)
    begin
      p = POS_L[47 - 4 * k -: 4];
      n = NEG_L[47 - 4 * k -: 4];
      if (c[5]) {p, n} = {n, p};
    end
    return {pend, e[7:6] == 2'h0, e[7:6] == 2'h1, e[7], e[7:6] == 2'h3,
            d, c == 6'h22, d & c[0], p, n};
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in   <= 1'b0;
    @(posedge mclk_in);
    d = rdata_out;
  endtask
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: read %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_sel(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: select %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #60000;
    err_total++;
    test_done;
  end
  initial
  begin
    {rst_n_in, wr_in, rd_in, start_q} <= 4'h0;
    addr_in  <= 8'h00;
    wdata_in <= 8'h00;
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    rd_reg(8'h07, r);
    cmp_reg(r, aims_pkg::AIMS_REG_RESET);
    cmp_sel(sel_w, exp_sel(8'h00, 1'b0));
    rd_reg(8'h06, r);
    cmp_reg(r, 8'h00);
    // Code 22 lands with reference 10, the one the sensor needs.
    for (int i = 0; i < 64; i++)
    begin
      v = {2'(i), 6'(i)};
      wr_reg(8'h07, v);
      rd_reg(8'h07, r);
      cmp_reg(r, v);
      cmp_sel(sel_w, exp_sel(v, 1'b0));
    end
    wr_reg(8'h07, 8'h89);
    repeat (25) @(posedge mclk_in);
    start_q <= 1'b1;
    @(posedge mclk_in);
    start_q <= 1'b0;
    @(posedge mclk_in);
    wr_reg(8'h07, 8'h5E);
    rd_reg(8'h07, r);
    cmp_reg(r, 8'h5E);
    cmp_sel(sel_w, exp_sel(8'h89, 1'b1));
    for (int n = 0; n < 40 && done_w !== 1'b1; n++) @(posedge mclk_in);
    if (done_w !== 1'b1)
    begin
      err_total++;
      $display("mismatch at %0t: no done pulse", $time);
    end
    repeat (2) @(posedge mclk_in);
    cmp_sel(sel_w, exp_sel(8'h5E, 1'b0));
    // A write in the done cycle wins over the one held back.
    repeat (25) @(posedge mclk_in);
    start_q <= 1'b1;
    @(posedge mclk_in);
    start_q <= 1'b0;
    wr_reg(8'h07, 8'h26);
    repeat (12) @(posedge mclk_in);
    wr_reg(8'h07, 8'hC3);
    repeat (2) @(posedge mclk_in);
    cmp_sel(sel_w, exp_sel(8'hC3, 1'b0));
    test_done;
  end
endmodule // adc_input_mux_select_bench
`default_nettype wire
